//--- src/flash_status_reg_two.sv
`timescale 1ns/1ps
`include "status_two_params.svh"
// Overview of operation
// - Suspend opcode 75h sets bit 7 after suspend
// - Resume, resets, 66h/99h clear suspend flag
// - Bit 6 inverts the block-protect region
// - Read-only lock flags bits 5:3, power-up 000
// - Programming byte 128 sets its lock flag
// - Locked security register rejects later programs
// - Security register 0 is always locked
// - Quad off: pins keep control functions
// - Quad on: pins become data lanes 2, 3
// - Quad bit gates only six quad opcodes
// - Bit 0 is writable upper protect select
// - Selects 00: write needs only write enable
// - Selects 10: writes blocked until reset
// - Selects 11 with lock: permanently unwritable
module flash_status_reg_two (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_n_o,
  input wire logic soft_rst_i,
  input wire logic op_suspended_i,
  input wire status_two_pkg::sec_prog_s sec_prog_i,
  output logic sec_prog_reject_o,
  input wire logic protect_select_lo_i,
  input wire logic permanent_lock_bit_i,
  input wire logic wr_enable_latch_i,
  input wire logic wp_n_i,
  input wire logic hold_rst_n_i,
  input wire logic region_hit_i,
  output logic region_protected_o,
  output logic [7:0] status_two_o,
  output logic quad_pin_enable_o,
  output logic wp_active_o,
  output logic hold_rst_active_o,
  output logic quad_cmd_allowed_o,
  output logic sr_write_allowed_o,
  output logic [7:0] last_opcode_o
);
  import status_two_pkg::*;

  // Link domain: shift in opcodes and data bytes on sck
  logic [7:0] sh_r;
  logic [2:0] bit_cnt_r;
  logic [1:0] byte_cnt_r;
  logic [7:0] op_r;
  logic [7:0] data_r;
  logic op_seen_r;
  logic wr_seen_r;
  logic [7:0] rd_snap_r;
  logic [7:0] out_sh_r;
  logic [7:0] shift_nxt;
  logic byte_end;

  assign shift_nxt = {sh_r[6:0], mosi_i};
  assign byte_end = (bit_cnt_r == 3'h7);

  // Frame counters; select high clears them even with the clock stopped
  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      bit_cnt_r <= 3'h0;
      byte_cnt_r <= 2'h0;
    end else begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      if (byte_end && byte_cnt_r != 2'h3) begin
        byte_cnt_r <= byte_cnt_r + 2'h1;
      end
    end
  end

  // Event flags stand from the byte end until select rises, several
  // core clocks, so the core synchroniser cannot miss them
  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      op_seen_r <= 1'b0;
      wr_seen_r <= 1'b0;
    end else begin
      if (byte_end && byte_cnt_r == 2'h0) begin
        op_seen_r <= 1'b1;
      end
      if (byte_end && byte_cnt_r == 2'h1 && op_r == `OP_WR_ST2) begin
        wr_seen_r <= 1'b1;
      end
    end
  end

  // Shift register and captured words; words hold until the next frame
  always_ff @(posedge sck_i) begin
    if (!cs_n_i) begin
      sh_r <= shift_nxt;
      if (byte_end && byte_cnt_r == 2'h0) begin
        op_r <= shift_nxt;
      end
      if (byte_end && byte_cnt_r == 2'h1 && op_r == `OP_WR_ST2) begin
        data_r <= shift_nxt;
      end
    end
  end

  // Read data leaves on falling edge, status snapshot taken at opcode
  always_ff @(negedge sck_i) begin
    if (cs_n_i) begin
      out_sh_r <= 8'h00;
    end else if (bit_cnt_r == 3'h0 && byte_cnt_r == 2'h1
                 && op_r == `OP_RD_ST2) begin
      out_sh_r <= rd_snap_r;
    end else begin
      out_sh_r <= {out_sh_r[6:0], 1'b0};
    end
  end

  assign miso_o = out_sh_r[7];
  assign miso_oe_n_o = cs_n_i | (op_r != `OP_RD_ST2);

  // Core domain: synchronise event flags and pins
  logic [2:0] op_sync_r;
  logic [2:0] wr_sync_r;
  logic [1:0] wp_sync_r;
  logic [1:0] hold_sync_r;
  logic op_evt;
  logic wr_evt;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      op_sync_r <= 3'h0;
      wr_sync_r <= 3'h0;
      wp_sync_r <= 2'h3;
      hold_sync_r <= 2'h3;
    end else begin
      op_sync_r <= {op_sync_r[1:0], op_seen_r};
      wr_sync_r <= {wr_sync_r[1:0], wr_seen_r};
      wp_sync_r <= {wp_sync_r[0], wp_n_i};
      hold_sync_r <= {hold_sync_r[0], hold_rst_n_i};
    end
  end

  assign op_evt = op_sync_r[1] & ~op_sync_r[2]; // Rising edge only
  assign wr_evt = wr_sync_r[1] & ~wr_sync_r[2];

  // Opcode word is stable for many cycles after its event flag arrives
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      last_opcode_o <= 8'h00;
    end else if (op_evt) begin
      last_opcode_o <= op_r;
    end
  end

  // Software reset needs 66h directly followed by 99h
  logic rst_armed_r;
  logic soft_rst_evt;
  assign soft_rst_evt = soft_rst_i
                        | (op_evt && rst_armed_r && op_r == `OP_RST);

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rst_armed_r <= 1'b0;
    end else if (op_evt) begin
      rst_armed_r <= (op_r == `OP_RST_EN);
    end
  end

  // Suspend flag: set by suspend after the array halts
  logic suspend_flag_req_r;
  logic suspend_flag_r;
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || soft_rst_evt) begin
      suspend_flag_req_r <= 1'b0;
      suspend_flag_r <= 1'b0;
    end else if (op_evt && op_r == `OP_RESUME) begin
      suspend_flag_req_r <= 1'b0;
      suspend_flag_r <= 1'b0;
    end else begin
      if (op_evt && op_r == `OP_SUSPEND) begin
        suspend_flag_req_r <= 1'b1;
      end
      if (suspend_flag_req_r && op_suspended_i) begin
        suspend_flag_r <= 1'b1;
      end
    end
  end

  // Security lock flags: sticky, survive every reset of this block
  logic [2:0] secure_lock_flags_r;
  logic lock_init_r = 1'b0;
  logic sec_locked;
  always_comb begin
    sec_locked = 1'b1;
    if (sec_prog_i.reg_sel != 2'h0) begin
      sec_locked = secure_lock_flags_r[sec_prog_i.reg_sel - 2'h1];
    end
  end
  assign sec_prog_reject_o = sec_prog_i.valid & sec_locked;

  always_ff @(posedge ref_clk_i) begin
    if (!lock_init_r) begin
      secure_lock_flags_r <= 3'b000;
      lock_init_r <= 1'b1;
    end else if (sec_prog_i.valid && !sec_locked
                 && sec_prog_i.byte_idx == `SEC_LAST_BYTE) begin
      secure_lock_flags_r[sec_prog_i.reg_sel - 2'h1] <= 1'b1;
    end
  end
  // Write protection decode
  logic complement_protect_r;
  logic quad_pin_enable_r;
  logic protect_select_hi_r;
  prot_mode_e mode;
  always_comb begin
    case ({protect_select_hi_r, protect_select_lo_i})
      2'b00: mode = PROT_SOFT;
      2'b01: mode = PROT_HARD;
      2'b10: mode = PROT_RLOCK;
      default: mode = permanent_lock_bit_i ? PROT_OTP : PROT_RLOCK;
    endcase
  end

  always_comb begin
    case (mode)
      PROT_SOFT: sr_write_allowed_o = wr_enable_latch_i;
      PROT_HARD: sr_write_allowed_o = wr_enable_latch_i
                                      & (quad_pin_enable_r | wp_sync_r[1]);
      PROT_RLOCK: sr_write_allowed_o = 1'b0;
      PROT_OTP: sr_write_allowed_o = 1'b0;
      default: sr_write_allowed_o = 1'b0;
    endcase
  end

  // Writable fields; reset lockdown releases the upper select bit
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || soft_rst_evt) begin
      complement_protect_r <= 1'b0;
      quad_pin_enable_r <= 1'b0;
      protect_select_hi_r <= (mode == PROT_OTP);
    end else if (wr_evt && sr_write_allowed_o) begin
      complement_protect_r <= data_r[`ST2_CMP_BIT];
      quad_pin_enable_r <= data_r[`ST2_QE_BIT];
      protect_select_hi_r <= data_r[`ST2_SP_HI_BIT];
    end
  end

  // Region inversion and pin function selection
  assign region_protected_o = region_hit_i ^ complement_protect_r;
  assign wp_active_o = ~quad_pin_enable_r & ~wp_sync_r[1];
  assign hold_rst_active_o = ~quad_pin_enable_r
                             & ~hold_sync_r[1];
  assign quad_pin_enable_o = quad_pin_enable_r;

  // Only the quad opcodes depend on the enable bit
  function automatic logic is_quad_op(input logic [7:0] op);
    is_quad_op = (op == `OP_QUAD_RD) || (op == `OP_XIP_RD)
                 || (op == `OP_XIP_RD_DW) || (op == `OP_QUAD_PP)
                 || (op == `OP_BURST_WRAP) || (op == `OP_QUAD_ID);
  endfunction
  assign quad_cmd_allowed_o = ~is_quad_op(last_opcode_o)
                              | quad_pin_enable_r;

  // Assembled register; reserved bit forced to zero
  assign status_two_o = {suspend_flag_r, complement_protect_r,
                         secure_lock_flags_r, 1'b0,
                         quad_pin_enable_r, protect_select_hi_r};

  // Snapshot for the link, taken in link domain from a settled word
  always_ff @(posedge sck_i) begin
    rd_snap_r <= status_two_o;
  end

  chk_suspend_set: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    suspend_flag_req_r && op_suspended_i && !soft_rst_evt
    && !(op_evt && op_r == `OP_RESUME) |=> suspend_flag_r)
    else $error("suspend flag not set");
  chk_resume_clear: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    op_evt && op_r == `OP_RESUME |=> !suspend_flag_r)
    else $error("suspend flag not cleared");
  chk_cmp_invert: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    region_protected_o == (region_hit_i != complement_protect_r))
    else $error("region inversion wrong");
  chk_lock_sticky: assert property (@(posedge ref_clk_i)
    disable iff (!lock_init_r)
    $past(lock_init_r) |-> (secure_lock_flags_r
    & $past(secure_lock_flags_r)) == $past(secure_lock_flags_r))
    else $error("lock flag dropped");
  chk_sec0_reject: assert property (@(posedge ref_clk_i)
    sec_prog_i.valid && sec_prog_i.reg_sel == 2'h0 |-> sec_prog_reject_o)
    else $error("register 0 writable");
  chk_quad_gate: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    !quad_pin_enable_r && is_quad_op(last_opcode_o) |-> !quad_cmd_allowed_o)
    else $error("quad opcode not gated");
  chk_rlock_block: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    protect_select_hi_r && !protect_select_lo_i |-> !sr_write_allowed_o)
    else $error("lockdown write allowed");
  chk_rsvd_zero: assert property (@(posedge ref_clk_i)
    !status_two_o[`ST2_RSVD_BIT])
    else $error("reserved bit set");

  // Lock, pin and protection checks
  chk_lock_set: assert property (@(posedge ref_clk_i)
    disable iff (!lock_init_r)
    sec_prog_i.valid && !sec_locked
    && sec_prog_i.byte_idx == `SEC_LAST_BYTE
    |=> secure_lock_flags_r != $past(secure_lock_flags_r))
    else $error("lock flag not set");
  chk_lock_reject: assert property (@(posedge ref_clk_i)
    sec_prog_i.valid && sec_prog_i.reg_sel != 2'h0
    && secure_lock_flags_r[sec_prog_i.reg_sel - 2'h1]
    |-> sec_prog_reject_o)
    else $error("locked register writable");
  chk_pins_quad: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    quad_pin_enable_r |-> !wp_active_o && !hold_rst_active_o)
    else $error("pin control active in quad mode");
  chk_pins_ctrl: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    !quad_pin_enable_r |-> wp_active_o == !wp_sync_r[1])
    else $error("write protect pin ignored");
  chk_soft_write: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    !protect_select_hi_r && !protect_select_lo_i
    |-> sr_write_allowed_o == wr_enable_latch_i)
    else $error("software mode write gate wrong");
  chk_otp_block: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    protect_select_hi_r && protect_select_lo_i && permanent_lock_bit_i
    |-> !sr_write_allowed_o)
    else $error("permanent lock write allowed");
  chk_otp_keep: assert property (@(posedge ref_clk_i)
    !rst_n_i && mode == PROT_OTP |=> protect_select_hi_r)
    else $error("permanent lock lost at reset");
  chk_write_lands: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i)
    wr_evt && sr_write_allowed_o && !soft_rst_evt
    |=> protect_select_hi_r == data_r[`ST2_SP_HI_BIT])
    else $error("upper select not written");
endmodule

//--- inc/status_two_params.svh
`ifndef STATUS_TWO_PARAMS_SVH
`define STATUS_TWO_PARAMS_SVH
// Opcodes seen on the serial link
`define OP_SUSPEND 8'h75
`define OP_RESUME 8'h7a
`define OP_RST_EN 8'h66
`define OP_RST 8'h99
`define OP_WREN 8'h06
`define OP_WR_ST2 8'h31
`define OP_RD_ST2 8'h35
`define OP_QUAD_RD 8'h6b
`define OP_XIP_RD 8'heb
`define OP_XIP_RD_DW 8'he7
`define OP_QUAD_PP 8'h32
`define OP_BURST_WRAP 8'h77
`define OP_QUAD_ID 8'h94
// Field positions
`define ST2_SUSPEND_FLAG_BIT 7
`define ST2_CMP_BIT 6
`define ST2_LOCK_HI 5
`define ST2_LOCK_LO 3
`define ST2_RSVD_BIT 2
`define ST2_QE_BIT 1
`define ST2_SP_HI_BIT 0
// Reset value and writable mask
`define ST2_RESET 8'h00
`define ST2_WR_MASK 8'h43
// Last byte index of a 128-byte security register
`define SEC_LAST_BYTE 7'h7f
`endif

//--- inc/status_two_pkg.sv
package status_two_pkg;
  // Security register program request from the array sequencer
  typedef struct packed {
    logic valid;
    logic [1:0] reg_sel;
    logic [6:0] byte_idx;
  } sec_prog_s;
  // Protection mode of the status registers
  typedef enum logic [1:0] {
    PROT_SOFT = 2'b00,
    PROT_HARD = 2'b01,
    PROT_RLOCK = 2'b11,
    PROT_OTP = 2'b10
  } prot_mode_e;
endpackage

//--- tb/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
  output logic sck_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i
);
  logic [7:0] rd_byte;
  // Link idles with clock still and select high
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // One byte, MSB first, 30 ns link clock, read bit taken on rising edge
  task automatic xfer(input logic [7:0] tx);
    for (int i = 7; i >= 0; i--) begin
      mosi_o = tx[i];
      #15 sck_o = 1'b1;
      rd_byte[i] = miso_i;
      #15 sck_o = 1'b0;
    end
  endtask
  // Opcode frame with optional data byte; quad opcodes are sent as asked
  task automatic frame(input logic [7:0] op, input logic [7:0] dat,
                       input logic with_dat);
    cs_n_o = 1'b0;
    #7;
    xfer(op);
    if (with_dat)
      xfer(dat);
    #15 cs_n_o = 1'b1;
    mosi_o = ~mosi_o; // Released line does not keep its last value
    #90;
  endtask
endmodule

//--- tb/flash_status_reg_two_tb.sv
`timescale 1ns/1ps
module flash_status_reg_two_tb;
  import status_two_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic sck, cs_n, mosi, miso, miso_oe_n, rej, reg_prot, quad_en;
  logic wp_act, hold_act, quad_ok, sr_wr_ok;
  logic [7:0] st2, last_op;
  logic soft_rst = 1'b0, op_suspend_flag = 1'b0, sel_lo = 1'b0, plock = 1'b0;
  logic wel = 1'b1, wp_n = 1'b1, hold_n = 1'b1, hit = 1'b1;
  sec_prog_s prog = '0;
  int mismatches = 0;
  int checks_done = 0;
  // Core clock
  always #5 ref_clk_i = ~ref_clk_i;
  spi_host_model i_host (.sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi),
    .miso_i(miso));
  flash_status_reg_two i_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .sck_i(sck), .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso),
    .miso_oe_n_o(miso_oe_n), .soft_rst_i(soft_rst),
    .op_suspended_i(op_suspend_flag), .sec_prog_i(prog),
    .sec_prog_reject_o(rej), .protect_select_lo_i(sel_lo),
    .permanent_lock_bit_i(plock), .wr_enable_latch_i(wel),
    .wp_n_i(wp_n), .hold_rst_n_i(hold_n), .region_hit_i(hit),
    .region_protected_o(reg_prot), .status_two_o(st2),
    .quad_pin_enable_o(quad_en), .wp_active_o(wp_act),
    .hold_rst_active_o(hold_act), .quad_cmd_allowed_o(quad_ok),
    .sr_write_allowed_o(sr_wr_ok), .last_opcode_o(last_op));
  // Compare and count
  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic do_reset;
    @(posedge ref_clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    wait_cyc(2);
  endtask
  task automatic op(input logic [7:0] code);
    i_host.frame(code, 8'h00, 1'b0);
    wait_cyc(6);
  endtask
  task automatic write_reg(input logic [7:0] d);
    i_host.frame(8'h31, d, 1'b1);
    wait_cyc(6);
  endtask
  task automatic read_reg(input logic [7:0] exp);
    i_host.frame(8'h35, 8'h00, 1'b1);
    check("read", exp, i_host.rd_byte);
  endtask
  task automatic prog_req(input logic [1:0] sel, input logic [6:0] idx,
                          input logic exp_rej);
    @(posedge ref_clk_i);
    prog <= '{1'b1, sel, idx};
    #1 check("reject", {7'h0, exp_rej}, {7'h0, rej});
    @(posedge ref_clk_i);
    prog <= '0;
    wait_cyc(2);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Cut a hung run short
  initial begin
    #900000;
    mismatches++;
    print_verdict();
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    wait_cyc(2);
    check("st2", 8'h00, st2);
    @(posedge ref_clk_i);
    wp_n <= 1'b0;
    hold_n <= 1'b0;
    wait_cyc(4);
    check("wp", 8'h01, {7'h0, wp_act});
    check("hold", 8'h01, {7'h0, hold_act});
    check("region", 8'h01, {7'h0, reg_prot});
    op(8'h6b);
    check("quad_ok", 8'h00, {7'h0, quad_ok});
    check("last_op", 8'h6b, last_op);
    write_reg(8'hff);
    check("st2", 8'h43, st2);
    check("qe pins", 8'h04, {quad_en, wp_act, hold_act});
    check("region", 8'h00, {7'h0, reg_prot});
    @(posedge ref_clk_i);
    hit <= 1'b0;
    wait_cyc(1);
    check("region", 8'h01, {7'h0, reg_prot});
    read_reg(8'h43);
    check("miso_oe", 8'h01, {7'h0, miso_oe_n});
    op(8'h6b);
    check("quad_ok", 8'h01, {7'h0, quad_ok});
    check("sr_wr", 8'h00, {7'h0, sr_wr_ok});
    write_reg(8'h00);
    check("st2", 8'h43, st2);
    @(posedge ref_clk_i);
    soft_rst <= 1'b1;
    @(posedge ref_clk_i);
    soft_rst <= 1'b0;
    wait_cyc(3);
    check("sp_hi", 8'h00, {7'h0, st2[0]});
    do_reset();
    check("st2", 8'h00, st2);
    @(posedge ref_clk_i);
    wel <= 1'b0;
    write_reg(8'h02);
    check("st2", 8'h00, st2);
    @(posedge ref_clk_i);
    wel <= 1'b1;
    op(8'h75);
    @(posedge ref_clk_i);
    op_suspend_flag <= 1'b1;
    wait_cyc(4);
    check("suspend_flag", 8'h01, {7'h0, st2[7]});
    @(posedge ref_clk_i);
    op_suspend_flag <= 1'b0;
    op(8'h7a);
    check("suspend_flag", 8'h00, {7'h0, st2[7]});
    op(8'h75);
    @(posedge ref_clk_i);
    op_suspend_flag <= 1'b1;
    wait_cyc(4);
    @(posedge ref_clk_i);
    op_suspend_flag <= 1'b0;
    op(8'h66);
    op(8'h99);
    check("suspend_flag", 8'h00, {7'h0, st2[7]});
    prog_req(2'd0, 7'h7f, 1'b1);
    prog_req(2'd1, 7'h10, 1'b0);
    prog_req(2'd1, 7'h7f, 1'b0);
    check("locks", 8'h01, {5'h0, st2[5:3]});
    prog_req(2'd1, 7'h00, 1'b1);
    prog_req(2'd2, 7'h7f, 1'b0);
    prog_req(2'd3, 7'h7f, 1'b0);
    do_reset();
    check("locks", 8'h07, {5'h0, st2[5:3]});
    @(posedge ref_clk_i);
    sel_lo <= 1'b1;
    wait_cyc(2);
    check("sr_wr", 8'h00, {7'h0, sr_wr_ok});
    @(posedge ref_clk_i);
    wp_n <= 1'b1;
    wait_cyc(3);
    check("sr_wr", 8'h01, {7'h0, sr_wr_ok});
    @(posedge ref_clk_i);
    sel_lo <= 1'b0;
    write_reg(8'h01);
    @(posedge ref_clk_i);
    sel_lo <= 1'b1;
    plock <= 1'b1;
    wait_cyc(2);
    check("sr_wr", 8'h00, {7'h0, sr_wr_ok});
    do_reset();
    write_reg(8'h02);
    check("st2", 8'h39, st2);
    print_verdict();
  end
endmodule
